// ===== i2csb_top.sv
`timescale 1ns/1ps
`include "i2csb_cfg.svh"

module i2csb_top #(
	parameter int CNT_W = 8
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic link_clk,
	input wire logic slave_en,
	input wire logic [6:0] slave_addr,
	input wire logic int_byte_en,
	input wire logic int_err_en,
	input wire logic csr_wr,
	input wire logic csr_ack,
	input wire logic err_clr,
	input wire logic dr_wr,
	input wire logic [7:0] dr_data,
	input wire logic rd_load,
	input wire logic [CNT_W-1:0] rd_init,
	input wire logic wr_load,
	input wire logic [CNT_W-1:0] wr_init,
	input wire logic status_clr,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic scl_oe_n,
	output logic sda_o,
	output logic sda_oe_n,
	output logic irq,
	output i2csb_pkg::i2csb_stat_s control_status_reg,
	output logic [7:0] rx_data,
	output logic wr_store,
	output logic [7:0] wr_store_data,
	output logic [CNT_W-1:0] read_space_remaining,
	output logic [CNT_W-1:0] write_space_remaining,
	output logic [`I2CSB_TSB_W-1:0] transfer_status_byte
);

	// Link domain: pins sampled on link_clk, which must run many times the bit rate
	logic [2:0] scl_sy_q, sda_sy_q, rel_sy_q;
	logic [1:0] en_sy_q;
	logic scl_f_q, sda_f_q;
	logic scl_f_d, sda_f_d;
	i2csb_pkg::i2csb_lst_e st_q, st_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] sh_q, sh_d;
	logic rw_q, rw_d, adr_q, adr_d, ackd_q, ackd_d, lmack_q, lmack_d, arm_q, arm_d;
	logic scl_oe_n_q, scl_oe_n_d, sda_oe_n_q, sda_oe_n_d;
	logic ev_tgl_q, ev_tgl_d, err_tgl_q, err_tgl_d;
	i2csb_pkg::i2csb_ev_s ev_q, ev_d;

	// CPU domain
	logic [2:0] ev_sy_q, err_sy_q;
	logic pend_q, err_q, dir_q, mack_q, irq_q, rel_tgl_q, wr_store_q, is_addr_q;
	i2csb_pkg::i2csb_ev_e kind_q;
	i2csb_pkg::i2csb_rel_s rel_q, rel_d;
	logic [7:0] shd_q, last_tx_q, rx_data_q, wr_store_data_q;
	logic [CNT_W-1:0] rd_cnt_q, wr_cnt_q;
	logic [`I2CSB_TSB_W-1:0] tsb_q, tsb_d;
	logic scl_o_q, sda_o_q;

	// Pin filter: level moves only once second and third stages agree
	assign scl_f_d = (scl_sy_q[1] == scl_sy_q[2]) ? scl_sy_q[2] : scl_f_q;
	assign sda_f_d = (sda_sy_q[1] == sda_sy_q[2]) ? sda_sy_q[2] : sda_f_q;

	wire scl_rise = scl_f_d & ~scl_f_q;
	wire scl_fall = ~scl_f_d & scl_f_q;
	wire scl_high = scl_f_d & scl_f_q;
	wire start_c = scl_high & sda_f_q & ~sda_f_d;
	wire stop_c = scl_high & ~sda_f_q & sda_f_d;
	wire en_ls = en_sy_q[1];
	wire rel_ev = rel_sy_q[1] ^ rel_sy_q[2];
	// Count of one is the first bit after ACK, where a repeated start or stop is legal
	wire mid_byte = ((st_q == i2csb_pkg::L_RX) || (st_q == i2csb_pkg::L_TX)) &&
		(cnt_q > 4'h1);

	always_ff @(posedge link_clk or negedge nrst) begin
		if (!nrst) begin
			scl_sy_q <= `I2CSB_SYNC_RST;
			sda_sy_q <= `I2CSB_SYNC_RST;
			rel_sy_q <= 3'h0;
			en_sy_q <= 2'h0;
			scl_f_q <= 1'b1;
			sda_f_q <= 1'b1;
		end else begin
			scl_sy_q <= {scl_sy_q[1:0], scl_i};
			sda_sy_q <= {sda_sy_q[1:0], sda_i};
			rel_sy_q <= {rel_sy_q[1:0], rel_tgl_q};
			en_sy_q <= {en_sy_q[0], slave_en};
			scl_f_q <= scl_f_d;
			sda_f_q <= sda_f_d;
		end
	end

	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		rw_d = rw_q;
		adr_d = adr_q;
		ackd_d = ackd_q;
		lmack_d = lmack_q;
		arm_d = arm_q;
		scl_oe_n_d = scl_oe_n_q;
		sda_oe_n_d = sda_oe_n_q;
		ev_tgl_d = ev_tgl_q;
		err_tgl_d = err_tgl_q;
		ev_d = ev_q;
		unique case (st_q)
			i2csb_pkg::L_IDLE: begin
			end
			i2csb_pkg::L_RX: begin
				if (scl_rise) begin
					sh_d = {sh_q[6:0], sda_f_q};
					cnt_d = cnt_q + 4'h1;
				end else if (scl_fall && (cnt_q == `I2CSB_BITS)) begin
					scl_oe_n_d = 1'b0;
					ev_tgl_d = ~ev_tgl_q;
					ev_d.kind = adr_q ? i2csb_pkg::EV_ADDR : i2csb_pkg::EV_RX;
					ev_d.data = sh_q;
					ev_d.mack = lmack_q;
					arm_d = 1'b0;
					st_d = i2csb_pkg::L_HOLD;
					if (adr_q) begin
						rw_d = sh_q[0];
					end
				end
			end
			// SDA settles one cycle before SCL is let go, so no false start or stop
			i2csb_pkg::L_HOLD: begin
				if (arm_q) begin
					scl_oe_n_d = 1'b1;
					arm_d = 1'b0;
					st_d = i2csb_pkg::L_ACK;
				end else if (rel_ev) begin
					ackd_d = rel_q.ack;
					sda_oe_n_d = ~rel_q.ack;
					arm_d = 1'b1;
				end
			end
			i2csb_pkg::L_ACK: begin
				if (scl_rise) begin
					arm_d = 1'b1;
				end else if (scl_fall && arm_q) begin
					cnt_d = 4'h0;
					adr_d = 1'b0;
					arm_d = 1'b0;
					if (ackd_q && adr_q && (rw_q == `I2CSB_RW_READ)) begin
						sh_d = rel_q.data;
						sda_oe_n_d = rel_q.data[7];
						st_d = i2csb_pkg::L_TX;
					end else if (!ackd_q && adr_q) begin
						sda_oe_n_d = 1'b1;
						st_d = i2csb_pkg::L_IGNORE;
					end else begin
						sda_oe_n_d = 1'b1;
						st_d = i2csb_pkg::L_RX;
					end
				end
			end
			i2csb_pkg::L_TX: begin
				if (scl_rise) begin
					cnt_d = cnt_q + 4'h1;
				end else if (scl_fall) begin
					if (cnt_q == `I2CSB_BITS) begin
						sda_oe_n_d = 1'b1;
						arm_d = 1'b0;
						st_d = i2csb_pkg::L_TACK;
					end else begin
						sh_d = {sh_q[6:0], 1'b0};
						sda_oe_n_d = sh_q[6];
					end
				end
			end
			i2csb_pkg::L_TACK: begin
				if (scl_rise) begin
					arm_d = 1'b1;
					lmack_d = (sda_f_q == `I2CSB_SDA_ACK);
				end else if (scl_fall && arm_q) begin
					scl_oe_n_d = 1'b0;
					ev_tgl_d = ~ev_tgl_q;
					ev_d.kind = i2csb_pkg::EV_TXACK;
					ev_d.data = sh_q;
					ev_d.mack = lmack_q;
					arm_d = 1'b0;
					st_d = i2csb_pkg::L_TWAIT;
				end
			end
			i2csb_pkg::L_TWAIT: begin
				if (arm_q) begin
					scl_oe_n_d = 1'b1;
					arm_d = 1'b0;
					st_d = lmack_q ? i2csb_pkg::L_TX : i2csb_pkg::L_IGNORE;
				end else if (rel_ev) begin
					arm_d = 1'b1;
					cnt_d = 4'h0;
					if (lmack_q) begin
						sh_d = rel_q.data;
						sda_oe_n_d = rel_q.data[7];
					end
				end
			end
			i2csb_pkg::L_IGNORE: begin
			end
		endcase
		if (!en_ls) begin
			st_d = i2csb_pkg::L_IDLE;
			scl_oe_n_d = 1'b1;
			sda_oe_n_d = 1'b1;
		end else if (start_c) begin
			if (mid_byte) begin
				err_tgl_d = ~err_tgl_q;
			end
			st_d = i2csb_pkg::L_RX;
			cnt_d = 4'h0;
			adr_d = 1'b1;
			scl_oe_n_d = 1'b1;
			sda_oe_n_d = 1'b1;
		end else if (stop_c) begin
			if (mid_byte) begin
				err_tgl_d = ~err_tgl_q;
			end
			st_d = i2csb_pkg::L_IDLE;
			scl_oe_n_d = 1'b1;
			sda_oe_n_d = 1'b1;
		end
	end

	always_ff @(posedge link_clk or negedge nrst) begin
		if (!nrst) begin
			st_q <= i2csb_pkg::L_IDLE;
			cnt_q <= 4'h0;
			sh_q <= `I2CSB_BYTE_RST;
			rw_q <= 1'b0;
			adr_q <= 1'b0;
			ackd_q <= 1'b0;
			lmack_q <= 1'b0;
			arm_q <= 1'b0;
			scl_oe_n_q <= 1'b1;
			sda_oe_n_q <= 1'b1;
			ev_tgl_q <= 1'b0;
			err_tgl_q <= 1'b0;
			ev_q <= '0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			rw_q <= rw_d;
			adr_q <= adr_d;
			ackd_q <= ackd_d;
			lmack_q <= lmack_d;
			arm_q <= arm_d;
			scl_oe_n_q <= scl_oe_n_d;
			sda_oe_n_q <= sda_oe_n_d;
			ev_tgl_q <= ev_tgl_d;
			err_tgl_q <= err_tgl_d;
			ev_q <= ev_d;
		end
	end

	// CPU side: event payload stays still while the link is stalled
	wire ev_edge = ev_sy_q[1] ^ ev_sy_q[2];
	wire err_edge = err_sy_q[1] ^ err_sy_q[2];
	wire ev_addr = ev_q.kind == i2csb_pkg::EV_ADDR;
	wire [7:0] addr_exp = {slave_addr, ev_q.data[0]};
	wire adr_match = ev_q.data == addr_exp;
	wire auto_nak = ev_edge && ev_addr && !adr_match;
	wire ev_take = ev_edge && !auto_nak;
	wire take = csr_wr && pend_q;
	wire kind_rx = kind_q == i2csb_pkg::EV_RX;
	wire wr_zero = wr_cnt_q == '0;
	wire wr_last = wr_cnt_q == CNT_W'(1);
	wire rd_zero = rd_cnt_q == '0;
	wire rx_ack = (wr_zero || wr_last) ? 1'b0 : csr_ack;
	wire rel_ack = kind_rx ? rx_ack : csr_ack;
	wire need_tx = (kind_q == i2csb_pkg::EV_TXACK) ? mack_q :
		((kind_q == i2csb_pkg::EV_ADDR) && (dir_q == `I2CSB_RW_READ) && csr_ack);
	wire [7:0] tx_pick = rd_zero ? last_tx_q : shd_q;
	wire do_tx = take && need_tx;
	wire do_store = take && kind_rx && !wr_zero;
	wire en_ls_cpu_ok = slave_en;
	wire pend_d = en_ls_cpu_ok & (ev_take | (pend_q & ~take & ~err_edge));
	wire err_d = err_edge | (err_q & ~err_clr);

	assign rel_d = auto_nak ? '{ack: 1'b0, data: `I2CSB_BYTE_RST} : '{ack: rel_ack, data: tx_pick};

	always_comb begin
		tsb_d = status_clr ? `I2CSB_TSB_RST : tsb_q;
		if (ev_take && ev_addr) begin
			tsb_d[`I2CSB_TSB_RD] = tsb_d[`I2CSB_TSB_RD] | ev_q.data[0];
			tsb_d[`I2CSB_TSB_WR] = tsb_d[`I2CSB_TSB_WR] | ~ev_q.data[0];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ev_sy_q <= 3'h0;
			err_sy_q <= 3'h0;
			pend_q <= 1'b0;
			err_q <= 1'b0;
			irq_q <= 1'b0;
			tsb_q <= `I2CSB_TSB_RST;
		end else begin
			ev_sy_q <= {ev_sy_q[1:0], ev_tgl_q};
			err_sy_q <= {err_sy_q[1:0], err_tgl_q};
			pend_q <= pend_d;
			err_q <= err_d;
			irq_q <= (pend_d & int_byte_en) | (err_d & int_err_en);
			tsb_q <= tsb_d;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			kind_q <= i2csb_pkg::EV_ADDR;
			is_addr_q <= 1'b0;
			dir_q <= 1'b0;
			mack_q <= 1'b0;
			rx_data_q <= `I2CSB_BYTE_RST;
		end else if (ev_take) begin
			kind_q <= ev_q.kind;
			is_addr_q <= ev_addr;
			rx_data_q <= ev_q.data;
			mack_q <= ev_q.mack;
			if (ev_addr) begin
				dir_q <= ev_q.data[0];
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rel_tgl_q <= 1'b0;
			rel_q <= '0;
		end else if (take || auto_nak) begin
			rel_tgl_q <= ~rel_tgl_q;
			rel_q <= rel_d;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			shd_q <= `I2CSB_BYTE_RST;
			last_tx_q <= `I2CSB_BYTE_RST;
			rd_cnt_q <= '0;
		end else begin
			if (dr_wr) begin
				shd_q <= dr_data;
			end
			if (do_tx) begin
				last_tx_q <= tx_pick;
			end
			// Software reload beats the per-byte decrement
			if (rd_load) begin
				rd_cnt_q <= rd_init;
			end else if (do_tx && !rd_zero) begin
				rd_cnt_q <= rd_cnt_q - CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_cnt_q <= '0;
			wr_store_q <= 1'b0;
			wr_store_data_q <= `I2CSB_BYTE_RST;
			scl_o_q <= 1'b0;
			sda_o_q <= 1'b0;
		end else begin
			wr_store_q <= do_store;
			if (do_store) begin
				wr_store_data_q <= rx_data_q;
			end
			if (wr_load) begin
				wr_cnt_q <= wr_init;
			end else if (do_store) begin
				wr_cnt_q <= wr_cnt_q - CNT_W'(1);
			end
		end
	end

	assign scl_o = scl_o_q;
	assign sda_o = sda_o_q;
	assign scl_oe_n = scl_oe_n_q;
	assign sda_oe_n = sda_oe_n_q;
	assign irq = irq_q;
	assign control_status_reg = '{pending: pend_q, is_addr: is_addr_q,
		dir_read: dir_q, master_ack: mack_q, bus_err: err_q};
	assign rx_data = rx_data_q;
	assign wr_store = wr_store_q;
	assign wr_store_data = wr_store_data_q;
	assign read_space_remaining = rd_cnt_q;
	assign write_space_remaining = wr_cnt_q;
	assign transfer_status_byte = tsb_q;

endmodule // i2csb_top

// ===== i2csb_cfg.svh
// How it works
// - Each finished matching address or data byte updates status and may interrupt.
// - Byte-complete and bus-error interrupts have separate enables.
// - After every byte that sets pending, the clock line is held low until software acts.
// - A declined address gives no more interrupts until the next address.
// - Every received address is answered with ACK or NAK.
// - While receiving, interrupt right after the eighth incoming bit.
// - Software gives the ACK/NAK choice through a control write.
// - That control write releases the stall, drives ACK/NAK, shifts next byte.
// - While sending, interrupt after the master's ACK/NAK; that bit is readable.
// - Next transmit byte is loaded, then a control write sends it.
// - A transfer is start, address, direction, data, then stop.
// - Works at 50, 100 and 400 kbit/s with a fast enough clock.
// - Separate read and write space counts fall by one per byte.
// - A started read or write sets its bit in the transfer status byte.
// - Reading past the buffer end resends the last byte.
// - Byte filling the last write space is stored and NAKed; later ones dropped.
// - Zero write space: every written byte is NAKed and not stored.
// - Address is the upper seven bits; low bit 0 write, 1 read.
// - Own address may be any value from 0 to 127.
// - Expected byte is own address shifted left with direction bit below.
// - Slave runs while the enable bit is set and stops when cleared.
`ifndef I2CSB_CFG_SVH
`define I2CSB_CFG_SVH

`define I2CSB_BITS 4'h8
`define I2CSB_SDA_ACK 1'b0
`define I2CSB_RW_READ 1'b1
`define I2CSB_TSB_RD 0
`define I2CSB_TSB_WR 1
`define I2CSB_TSB_W 2
`define I2CSB_TSB_RST 2'h0
`define I2CSB_BYTE_RST 8'h00
`define I2CSB_SYNC_RST 3'h7

`endif

// ===== i2csb_pkg.sv
package i2csb_pkg;

	typedef enum logic [1:0] {EV_ADDR, EV_RX, EV_TXACK} i2csb_ev_e;

	typedef enum logic [2:0] {
		L_IDLE, L_RX, L_HOLD, L_ACK, L_TX, L_TACK, L_TWAIT, L_IGNORE
	} i2csb_lst_e;

	typedef struct packed {
		i2csb_ev_e kind;
		logic [7:0] data;
		logic mack;
	} i2csb_ev_s;

	typedef struct packed {
		logic ack;
		logic [7:0] data;
	} i2csb_rel_s;

	typedef struct packed {
		logic pending;
		logic is_addr;
		logic dir_read;
		logic master_ack;
		logic bus_err;
	} i2csb_stat_s;

endpackage

// ===== i2csb_chk.sv
`timescale 1ns/1ps
`include "i2csb_cfg.svh"
module i2csb_chk #(
	parameter int CNT_W = 8
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic slave_en,
	input wire logic [6:0] slave_addr,
	input wire logic int_byte_en,
	input wire logic csr_wr,
	input wire logic wr_load,
	input wire logic rd_load,
	input wire logic scl_oe_n,
	input wire logic irq,
	input wire i2csb_pkg::i2csb_stat_s control_status_reg,
	input wire logic [7:0] rx_data,
	input wire logic wr_store,
	input wire logic [CNT_W-1:0] read_space_remaining,
	input wire logic [CNT_W-1:0] write_space_remaining,
	input wire logic [`I2CSB_TSB_W-1:0] transfer_status_byte
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	wire logic pend = control_status_reg.pending;
	wire logic adr = control_status_reg.is_addr;
	// Loads win over decrement, so they are kept out
	wire logic wr_ev = csr_wr && pend && !adr && !control_status_reg.dir_read && !wr_load;
	wire logic [CNT_W-1:0] wsr = write_space_remaining;
	property p_irq_on;
		pend && int_byte_en && $stable(int_byte_en) |-> irq;
	endproperty
	a_irq_on: assert property (p_irq_on) else $error("irq low while pending");
	property p_irq_off;
		!pend && !control_status_reg.bus_err |-> !irq;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq without cause");
	property p_release;
		pend && csr_wr |=> !pend;
	endproperty
	a_release: assert property (p_release) else $error("pending kept after write");
	property p_hold;
		pend && !csr_wr && slave_en |=> pend || control_status_reg.bus_err;
	endproperty
	a_hold: assert property (p_hold) else $error("pending lost unserviced");
	property p_stall;
		pend |-> !scl_oe_n;
	endproperty
	a_stall: assert property (p_stall) else $error("clock not stalled");
	property p_addr;
		$rose(pend) && adr |-> rx_data == {slave_addr, control_status_reg.dir_read};
	endproperty
	a_addr: assert property (p_addr) else $error("address event mismatch");
	property p_tsb;
		$rose(pend) && adr |->
			(control_status_reg.dir_read ? transfer_status_byte[0] : transfer_status_byte[1]);
	endproperty
	a_tsb: assert property (p_tsb) else $error("status byte not set");
	property p_store;
		wr_ev && wsr != '0 |-> ##[1:2] wr_store;
	endproperty
	a_store: assert property (p_store) else $error("byte not stored");
	property p_nostore;
		wr_ev && wsr == '0 |=> (!wr_store)[*2];
	endproperty
	a_nostore: assert property (p_nostore) else $error("byte stored with no space");
	property p_rfloor;
		read_space_remaining == '0 && !rd_load |=> read_space_remaining == '0;
	endproperty
	a_rfloor: assert property (p_rfloor) else $error("read space below zero");
	property p_wdec;
		wsr != $past(wsr) && !$past(wr_load) |-> wsr == CNT_W'($past(wsr) - 1);
	endproperty
	a_wdec: assert property (p_wdec) else $error("write space step not one");
endmodule // i2csb_chk

bind i2csb_top i2csb_chk #(.CNT_W(CNT_W)) u_chk (.clk(clk), .nrst(nrst), .slave_en(slave_en),
	.slave_addr(slave_addr), .int_byte_en(int_byte_en), .csr_wr(csr_wr), .wr_load(wr_load),
	.rd_load(rd_load), .scl_oe_n(scl_oe_n), .irq(irq), .control_status_reg(control_status_reg),
	.rx_data(rx_data), .wr_store(wr_store), .read_space_remaining(read_space_remaining),
	.write_space_remaining(write_space_remaining), .transfer_status_byte(transfer_status_byte));

// ===== i2csb_bfm.sv
`timescale 1ns/1ps
module i2csb_bfm (
	input wire logic scl_w,
	input wire logic sda_w,
	output logic scl_m,
	output logic sda_m,
	output logic hang
);
	localparam int Q = 150;
	initial begin
		scl_m = 1'h1;
		sda_m = 1'h1;
		hang = 1'h0;
	end
	// Slave may stretch the clock; bounded wait
	task automatic rise();
		int n;
		n = 0;
		scl_m = 1'h1;
		while (scl_w !== 1'h1 && n < 5000) begin
			#10;
			n++;
		end
		if (n >= 5000)
			hang = 1'h1;
		#Q;
	endtask
	task automatic bit_io(input logic b, output logic r);
		sda_m = b;
		#Q;
		rise();
		r = sda_w;
		scl_m = 1'h0;
		#Q;
	endtask
	task automatic start();
		sda_m = 1'h1;
		#Q;
		rise();
		sda_m = 1'h0;
		#Q;
		scl_m = 1'h0;
		#Q;
	endtask
	task automatic stop();
		sda_m = 1'h0;
		#Q;
		rise();
		sda_m = 1'h1;
		#Q;
	endtask
	// MSB first, ninth bit is the acknowledge
	task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
			output logic ack);
		for (int i = 7; i >= 0; i--)
			bit_io(tx[i], rx[i]);
		bit_io(mack, ack);
	endtask
endmodule // i2csb_bfm

// ===== tb_top.sv
`timescale 1ns/1ps
`include "i2csb_cfg.svh"
module tb_top;
	logic clk, link_clk, nrst, slave_en, csr_wr, csr_ack, dr_wr, rd_load, wr_load;
	logic [7:0] dr_data, rd_init, wr_init, rx_data, wr_store_data, rsr, wsr, rx, last_st;
	logic scl_m, sda_m, hang, scl_o, scl_oe_n, sda_o, sda_oe_n, irq, wr_store, ack;
	logic int_byte_en, int_err_en, err_clr, status_clr;
	logic [`I2CSB_TSB_W-1:0] tsb;
	i2csb_pkg::i2csb_stat_s csr;
	wire logic scl_w = scl_m & (scl_oe_n | scl_o);
	wire logic sda_w = sda_m & (sda_oe_n | sda_o);
	int err_total, n_tests, n_store;
	i2csb_top dut (.clk(clk), .nrst(nrst), .link_clk(link_clk), .slave_en(slave_en),
		.slave_addr(7'h48), .int_byte_en(int_byte_en), .int_err_en(int_err_en), .csr_wr(csr_wr),
		.csr_ack(csr_ack), .err_clr(err_clr), .dr_wr(dr_wr), .dr_data(dr_data), .rd_load(rd_load),
		.rd_init(rd_init), .wr_load(wr_load), .wr_init(wr_init), .status_clr(status_clr),
		.scl_i(scl_w), .sda_i(sda_w), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_o(sda_o),
		.sda_oe_n(sda_oe_n), .irq(irq), .control_status_reg(csr), .rx_data(rx_data),
		.wr_store(wr_store), .wr_store_data(wr_store_data), .read_space_remaining(rsr),
		.write_space_remaining(wsr), .transfer_status_byte(tsb));
	i2csb_bfm m (.scl_w(scl_w), .sda_w(sda_w), .scl_m(scl_m), .sda_m(sda_m), .hang(hang));
	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end
	initial begin
		link_clk = 1'h0;
		#1.7;
		forever #3 link_clk = ~link_clk;
	end
	always @(posedge clk) if (wr_store === 1'h1) begin
		n_store++;
		last_st <= wr_store_data;
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		if (hang !== 1'h0)
			err_total++;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic pulse(ref logic s);
		s = 1'h1;
		@(posedge clk);
		#1;
		s = 1'h0;
	endtask
	// must: 0 no event, 1 event, 2 either; sel picks the field checked
	task automatic serve(input logic [1:0] must, input logic a, input logic isadr,
			input logic [1:0] sel, input logic [7:0] d, input logic [8:0] ld);
		int n;
		n = 0;
		while (csr.pending !== 1'h1 && n < 3000) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (must != 2'h2)
			chk(csr.pending, must[0]);
		if (csr.pending === 1'h1) begin
			chk(irq, int_byte_en);
			chk(csr.is_addr, isadr);
			if (sel == 2'h1)
				chk(rx_data, d);
			if (sel == 2'h2)
				chk(csr.master_ack, d);
			dr_data = ld[7:0];
			if (ld[8])
				pulse(dr_wr);
			csr_ack = a;
			pulse(csr_wr);
			chk(csr.pending, 1'h0);
		end
	endtask
	task automatic step(input logic [7:0] tx, input logic mack, input logic [1:0] must,
			input logic a, input logic isadr, input logic [1:0] sel, input logic [7:0] d,
			input logic [8:0] ld);
		fork
			m.xfer(tx, mack, rx, ack);
			serve(must, a, isadr, sel, d, ld);
		join
	endtask
	initial begin
		{nrst, slave_en, csr_wr, csr_ack, dr_wr, rd_load, wr_load} = 7'h0;
		{dr_data, rd_init, wr_init} = 24'h0;
		{int_byte_en, int_err_en, err_clr, status_clr} = 4'hc;
		repeat (8) @(posedge clk);
		#1;
		nrst = 1'h1;
		slave_en = 1'h1;
		{rd_init, wr_init} = 16'h0202;
		{rd_load, wr_load} = 2'h3;
		@(posedge clk);
		#1;
		{rd_load, wr_load} = 2'h0;
		repeat (20) @(posedge clk);
		chk(tsb, 8'h00);
		m.start();
		step(8'h90, 1'h1, 2'h1, 1'h1, 1'h1, 2'h1, 8'h90, 9'h000);
		chk(ack, 8'h00);
		chk(tsb, 8'h02);
		step(8'ha5, 1'h1, 2'h1, 1'h1, 1'h0, 2'h1, 8'ha5, 9'h000);
		chk(ack, 8'h00);
		chk(last_st, 8'ha5);
		chk(wsr, 8'h01);
		step(8'h3c, 1'h1, 2'h1, 1'h1, 1'h0, 2'h1, 8'h3c, 9'h000);
		chk(ack, 8'h01);
		chk(last_st, 8'h3c);
		chk(wsr, 8'h00);
		step(8'h77, 1'h1, 2'h1, 1'h1, 1'h0, 2'h1, 8'h77, 9'h000);
		chk(ack, 8'h01);
		chk(n_store, 8'h02);
		m.stop();
		@(posedge clk);
		#1;
		int_byte_en = 1'h0;
		m.start();
		step(8'h90, 1'h1, 2'h1, 1'h0, 1'h1, 2'h1, 8'h90, 9'h000);
		chk(ack, 8'h01);
		step(8'h55, 1'h1, 2'h0, 1'h1, 1'h0, 2'h0, 8'h00, 9'h000);
		chk(ack, 8'h01);
		m.stop();
		@(posedge clk);
		#1;
		int_byte_en = 1'h1;
		m.start();
		step(8'h92, 1'h1, 2'h0, 1'h1, 1'h1, 2'h0, 8'h00, 9'h000);
		chk(ack, 8'h01);
		m.stop();
		m.start();
		step(8'h91, 1'h1, 2'h1, 1'h1, 1'h1, 2'h1, 8'h91, 9'h15a);
		chk(ack, 8'h00);
		chk(tsb[0], 8'h01);
		chk(rsr, 8'h01);
		step(8'hff, 1'h0, 2'h1, 1'h1, 1'h0, 2'h2, 8'h01, 9'h1c3);
		chk(rx, 8'h5a);
		chk(rsr, 8'h00);
		step(8'hff, 1'h0, 2'h1, 1'h1, 1'h0, 2'h2, 8'h01, 9'h1ee);
		chk(rx, 8'hc3);
		chk(rsr, 8'h00);
		step(8'hff, 1'h1, 2'h2, 1'h1, 1'h0, 2'h0, 8'h00, 9'h000);
		chk(rx, 8'hc3);
		m.stop();
		@(posedge clk);
		#1;
		slave_en = 1'h0;
		m.start();
		step(8'h90, 1'h1, 2'h0, 1'h1, 1'h1, 2'h0, 8'h00, 9'h000);
		chk(ack, 8'h01);
		m.stop();
		@(posedge clk);
		#1;
		slave_en = 1'h1;
		repeat (4) @(posedge clk);
		m.start();
		repeat (3) m.bit_io(1'h1, ack);
		m.stop();
		@(posedge clk);
		#1;
		chk(csr.bus_err, 8'h01);
		chk(irq, 8'h01);
		int_err_en = 1'h0;
		@(posedge clk);
		#1;
		chk(irq, 8'h00);
		int_err_en = 1'h1;
		pulse(err_clr);
		chk(csr.bus_err, 8'h00);
		chk(irq, 8'h00);
		pulse(status_clr);
		chk(tsb, 8'h00);
		stop_test();
	end
	initial begin
		repeat (90000) @(posedge clk);
		err_total++;
		stop_test();
	end
endmodule // tb_top
